// ---- rtl/sfbr_clkdiv.v ----
`timescale 1ns/10ps
`include "sfbr_defines.vh"
module sfbr_clkdiv (
	// clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// ratio select
	input  wire [1:0] ratio,
	// flash clock and its rising-edge enable
	output wire       flash_clock_out,
	output wire       rise_en
);
	reg [1:0] phase_reg;
	reg [1:0] phase_next;

	// divide by 1 passes the memory clock straight through; the others come from a flop
	always @* begin
		case (ratio)
			`SFBR_RATIO_2: phase_next = {1'b0, ~phase_reg[0]};
			`SFBR_RATIO_4: phase_next = phase_reg + 2'h1;
			default:       phase_next = 2'h0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_next;
	end

	assign flash_clock_out = (ratio == `SFBR_RATIO_1) ? aclk :
		(ratio == `SFBR_RATIO_2) ? phase_reg[0] : phase_reg[1]; // R1
	// high in the memory cycle that starts with a flash clock rise
	assign rise_en = (ratio == `SFBR_RATIO_1) ? 1'b1 :
		(ratio == `SFBR_RATIO_2) ? phase_reg[0] : (phase_reg == 2'h2);
endmodule // sfbr_clkdiv

// ---- rtl/sfbr_defines.vh ----
`ifndef SFBR_DEFINES_VH
`define SFBR_DEFINES_VH

// register byte offsets
`define SFBR_CLK_CTRL_OFF      8'h00
`define SFBR_SYNC_CFG_OFF      8'h04
`define SFBR_READ_ADDR_OFF     8'h08
`define SFBR_COMMAND_OFF       8'h0C
`define SFBR_STATUS_OFF        8'h10
`define SFBR_READ_DATA_OFF     8'h14

// field positions
`define SFBR_HALF_SEL_BIT      0
`define SFBR_QUARTER_SEL_BIT   1
`define SFBR_LAT_FIELD_LSB     0
`define SFBR_LAT_FIELD_MSB     3
`define SFBR_BURST_FIELD_LSB   4
`define SFBR_BURST_FIELD_MSB   6
`define SFBR_START_BIT         0

// reset values
`define SFBR_CLK_CTRL_RST      2'h0
`define SFBR_LAT_FIELD_RST     4'h4
`define SFBR_BURST_FIELD_RST   3'h7
`define SFBR_READ_ADDR_RST     26'h0000000

// division ratio codes
`define SFBR_RATIO_1           2'h0
`define SFBR_RATIO_2           2'h1
`define SFBR_RATIO_4           2'h2

// address-valid pulse width in memory clocks per ratio
`define SFBR_ADV_CYC_1         5'h01
`define SFBR_ADV_CYC_2         5'h03
`define SFBR_ADV_CYC_4         5'h07

// output-enable release to chip-select release in memory clocks
`define SFBR_CEH_CYC_1         5'h04
`define SFBR_CEH_CYC_2         5'h08
`define SFBR_CEH_CYC_4         5'h10

// latency field to code: field minus this offset (0100 gives 3)
`define SFBR_LAT_OFFSET        4'h1
`define SFBR_LAT_MIN           4'h1

// axi responses
`define SFBR_RESP_OKAY         2'h0
`define SFBR_RESP_SLVERR       2'h2

`endif

// ---- rtl/sfbr_fifo.v ----
`timescale 1ns/10ps
module sfbr_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	// fill level
	output wire [AW:0]      level
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign level     = count_reg;

	always @(posedge aclk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // sfbr_fifo

// ---- rtl/sfbr_top.v ----
// Contract
// R1: flash clock is the memory clock divided by 1, 2 or 4.
// R2: ratio 1 with no select bits, 2 with half only, 4 whenever quarter set.
// R3: column strobe serves as address valid, low 1, 3 or 7 memory clocks.
// R4: latency code comes from the software latency field in sync config.
// R5: latency field value 0100 means a code of three flash clocks.
// R6: data is captured on the flash edge the code selects after address valid.
// R7: software picks the code from flash delays over the clock period, rounded up.
// R8: remaining burst words captured on successive flash edges, then oe and cs released.
`timescale 1ns/10ps
`include "sfbr_defines.vh"
module sfbr_top (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// flash pins
	output wire        flash_clock_out,
	output wire [25:0] flash_addr,
	output wire        chip_select_n,
	output wire        column_strobe_n,
	output wire        output_enable_n,
	input  wire [31:0] flash_data_in
);
	////////////////////////////////////////////////////////////////////////////////
	localparam S_IDLE  = 3'h0;
	localparam S_SETUP = 3'h1;
	localparam S_ADV   = 3'h2;
	localparam S_WAIT  = 3'h3;
	localparam S_HOLD  = 3'h4;

	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				merge_bytes[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
		end
	endfunction

	// per-ratio figure picker: one, two, four
	function [4:0] by_ratio;
		input [1:0] r;
		input [4:0] v1;
		input [4:0] v2;
		input [4:0] v4;
		begin
			case (r)
				`SFBR_RATIO_2: by_ratio = v2;
				`SFBR_RATIO_4: by_ratio = v4;
				default:       by_ratio = v1;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg [1:0]  clk_ctrl_reg;
	reg [3:0]  lat_field_reg;
	reg [2:0]  burst_field_reg;
	reg [25:0] read_addr_reg;
	reg        start_pend_reg;
	// axi state
	reg        aw_full_reg;
	reg [7:0]  aw_addr_reg;
	reg        w_full_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0]  rresp_reg;
	// sequencer
	reg [2:0]  state_reg;
	reg [4:0]  cnt_reg;
	reg [3:0]  edge_reg;
	reg [3:0]  beat_reg;
	reg [1:0]  run_ratio_reg;
	reg [3:0]  run_code_reg;
	reg [3:0]  run_len_reg;
	reg        cs_n_reg;
	reg        adv_n_reg;
	reg        oe_n_reg;
	reg [1:2]  cap_d_reg;
	reg [31:0] din_s1_reg;
	reg [31:0] din_s2_reg;

	wire [1:0]  ratio;
	wire        rise_en;
	wire [3:0]  latency_code;
	wire [3:0]  burst_len;
	wire        do_write;
	wire        ar_hs;
	wire        pop_data;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [31:0] fifo_out_data;
	wire [3:0]  fifo_level;
	wire        cap_now;
	wire        cap_late;
	wire        cap_edge;
	wire [31:0] wr_word;
	wire [31:0] merged_word;

	////////////////////////////////////////////////////////////////////////////////
	assign ratio = clk_ctrl_reg[`SFBR_QUARTER_SEL_BIT] ? `SFBR_RATIO_4 :
		(clk_ctrl_reg[`SFBR_HALF_SEL_BIT] ? `SFBR_RATIO_2 : `SFBR_RATIO_1); // R2

	// field 0100 gives code 3; the lowest fields clamp to one flash clock
	assign latency_code = (lat_field_reg > `SFBR_LAT_OFFSET) ?
		lat_field_reg - `SFBR_LAT_OFFSET : `SFBR_LAT_MIN; // R4 R5
	assign burst_len = {1'b0, burst_field_reg} + 4'h1;

	sfbr_clkdiv u_clkdiv (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.ratio           (ratio),
		.flash_clock_out (flash_clock_out),
		.rise_en         (rise_en)
	);

	////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order, response after both
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_word       = (aw_addr_reg == `SFBR_CLK_CTRL_OFF) ? {30'h00000000, clk_ctrl_reg} :
		(aw_addr_reg == `SFBR_SYNC_CFG_OFF) ? {25'h0000000, burst_field_reg, lat_field_reg} :
		{6'h00, read_addr_reg};
	assign merged_word   = merge_bytes(wr_word, w_data_reg, w_strb_reg);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg     <= 1'b0;
			aw_addr_reg     <= 8'h00;
			w_full_reg      <= 1'b0;
			w_data_reg      <= 32'h00000000;
			w_strb_reg      <= 4'h0;
			bvalid_reg      <= 1'b0;
			bresp_reg       <= `SFBR_RESP_OKAY;
			clk_ctrl_reg    <= `SFBR_CLK_CTRL_RST;
			lat_field_reg   <= `SFBR_LAT_FIELD_RST;
			burst_field_reg <= `SFBR_BURST_FIELD_RST;
			read_addr_reg   <= `SFBR_READ_ADDR_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				bvalid_reg <= 1'b0;
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= `SFBR_RESP_OKAY;
				case (aw_addr_reg)
					`SFBR_CLK_CTRL_OFF:
						clk_ctrl_reg <= merged_word[1:0];
					`SFBR_SYNC_CFG_OFF: begin
						lat_field_reg   <= w_strb_reg[0] ?
							w_data_reg[`SFBR_LAT_FIELD_MSB:`SFBR_LAT_FIELD_LSB] : lat_field_reg;
						burst_field_reg <= w_strb_reg[0] ?
							w_data_reg[`SFBR_BURST_FIELD_MSB:`SFBR_BURST_FIELD_LSB] : burst_field_reg;
					end
					`SFBR_READ_ADDR_OFF:
						read_addr_reg <= merged_word[25:0];
					`SFBR_COMMAND_OFF: ;
					default:
						bresp_reg <= `SFBR_RESP_SLVERR;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel: answer one cycle after the address; reading data pops the fifo
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;
	assign pop_data      = ar_hs && ({s_axi_araddr[7:2], 2'h0} == `SFBR_READ_DATA_OFF);

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= `SFBR_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				rvalid_reg <= 1'b0;
			if (ar_hs) begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= `SFBR_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'h0})
					`SFBR_CLK_CTRL_OFF:  rdata_reg <= {30'h00000000, clk_ctrl_reg};
					`SFBR_SYNC_CFG_OFF:  rdata_reg <= {25'h0000000, burst_field_reg, lat_field_reg};
					`SFBR_READ_ADDR_OFF: rdata_reg <= {6'h00, read_addr_reg};
					`SFBR_COMMAND_OFF:   rdata_reg <= 32'h00000000;
					`SFBR_STATUS_OFF:    rdata_reg <= {24'h000000, fifo_level, 1'b0,
						start_pend_reg, fifo_out_valid, (state_reg != S_IDLE)};
					`SFBR_READ_DATA_OFF: rdata_reg <= fifo_out_valid ? fifo_out_data : 32'h00000000;
					default: begin
						rdata_reg <= 32'h00000000;
						rresp_reg <= `SFBR_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data pins pass two flops before use, so capture is delayed to match
	always @(posedge aclk) begin
		if (!aresetn) begin
			din_s1_reg <= 32'h00000000;
			din_s2_reg <= 32'h00000000;
		end else begin
			din_s1_reg <= flash_data_in;
			din_s2_reg <= din_s1_reg;
		end
	end

	// at ratio 1 the deciding edge is itself a flash rise, so the flash only sees
	// address valid one rise later and every beat is taken one memory clock later
	assign cap_late = (run_ratio_reg == `SFBR_RATIO_1);
	assign cap_edge = cap_late ? (edge_reg >= run_code_reg) :
		(edge_reg + 4'h1 >= run_code_reg);
	assign cap_now = (state_reg == S_ADV || state_reg == S_WAIT) && rise_en &&
		cap_edge && (beat_reg < run_len_reg); // R6 R8

	// a burst only starts into an empty fifo, so capture never meets a full one
	sfbr_fifo #(
		.WIDTH (32),
		.DEPTH (8),
		.AW    (3)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (cap_d_reg[2]),
		.in_ready  (fifo_in_ready),
		.in_data   (din_s2_reg),
		.out_valid (fifo_out_valid),
		.out_ready (pop_data),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer; burst counts use the ratio frozen at launch, the divider does not, so software should not change it mid-read
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg      <= S_IDLE;
			cnt_reg        <= 5'h00;
			edge_reg       <= 4'h0;
			beat_reg       <= 4'h0;
			run_ratio_reg  <= `SFBR_RATIO_1;
			run_code_reg   <= `SFBR_LAT_MIN;
			run_len_reg    <= 4'h1;
			cs_n_reg       <= 1'b1;
			adv_n_reg      <= 1'b1;
			oe_n_reg       <= 1'b1;
			cap_d_reg      <= 2'h0;
			start_pend_reg <= 1'b0;
		end else begin
			cap_d_reg <= {cap_now && fifo_in_ready, cap_d_reg[1]};
			if (cap_now) begin
				beat_reg <= beat_reg + 4'h1;
			end
			if (rise_en && edge_reg != 4'hF)
				edge_reg <= edge_reg + 4'h1;
			case (state_reg)
				S_IDLE: begin
					if (start_pend_reg && fifo_level == 4'h0) begin
						start_pend_reg <= 1'b0;
						run_ratio_reg  <= ratio;
						run_code_reg   <= latency_code; // R4
						run_len_reg    <= burst_len;
						cs_n_reg       <= 1'b0;
						beat_reg       <= 4'h0;
						state_reg      <= S_SETUP;
					end
				end
				S_SETUP: begin
					// address and chip select lead address valid by at least one cycle
					if (rise_en) begin
						adv_n_reg <= 1'b0;
						edge_reg  <= 4'h0;
						cnt_reg   <= by_ratio(run_ratio_reg, `SFBR_ADV_CYC_1,
							`SFBR_ADV_CYC_2, `SFBR_ADV_CYC_4) - 5'h01; // R3
						state_reg <= S_ADV;
					end
				end
				S_ADV: begin
					if (cnt_reg == 5'h00) begin
						adv_n_reg <= 1'b1;
						oe_n_reg  <= 1'b0;
						state_reg <= S_WAIT;
					end else
						cnt_reg <= cnt_reg - 5'h01; // R3
				end
				S_WAIT: begin
					if (beat_reg == run_len_reg || (cap_now && beat_reg + 4'h1 == run_len_reg)) begin
						oe_n_reg  <= 1'b1;
						cnt_reg   <= by_ratio(run_ratio_reg, `SFBR_CEH_CYC_1,
							`SFBR_CEH_CYC_2, `SFBR_CEH_CYC_4) - 5'h01; // R8
						state_reg <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (cnt_reg == 5'h00) begin
						cs_n_reg  <= 1'b1; // R8
						state_reg <= S_IDLE;
					end else
						cnt_reg <= cnt_reg - 5'h01;
				end
				default: state_reg <= S_IDLE;
			endcase
			// set wins over the clear taken when the burst is launched
			if (do_write && aw_addr_reg == `SFBR_COMMAND_OFF && w_strb_reg[0] &&
				w_data_reg[`SFBR_START_BIT])
				start_pend_reg <= 1'b1;
		end
	end

	assign flash_addr      = read_addr_reg;
	assign chip_select_n   = cs_n_reg;
	assign column_strobe_n = adv_n_reg;
	assign output_enable_n = oe_n_reg;
endmodule // sfbr_top

// ---- test/sfbr_asserts.sv ----
`timescale 1ns/10ps
module sfbr_asserts (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register writes
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	// flash pins
	input wire logic        flash_clock_out,
	input wire logic        chip_select_n,
	input wire logic        column_strobe_n,
	input wire logic        output_enable_n
);
	logic [2:0] div_reg;
	logic [2:0] div_next;
	logic [2:0] settle_reg;
	logic [3:0] adv_cnt_reg;
	logic [5:0] ceh_cnt_reg;
	logic       seen_oe_reg;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////
	// shadow of the ratio; the master offers address and data together
	always_comb begin
		div_next = div_reg;
		if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 8'h00)
			div_next = s_axi_wdata[1] ? 3'h4 : (s_axi_wdata[0] ? 3'h2 : 3'h1);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 3'h1;
			settle_reg <= 3'h0;
			adv_cnt_reg <= 4'h0;
			ceh_cnt_reg <= 6'h00;
			seen_oe_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			// clock pin needs a few cycles to settle after a ratio change
			settle_reg <= (div_next != div_reg) ? 3'h0 : settle_reg + {2'h0, settle_reg != 3'h7};
			adv_cnt_reg <= column_strobe_n ? 4'h0 : adv_cnt_reg + 4'h1;
			seen_oe_reg <= !chip_select_n && (seen_oe_reg || !output_enable_n);
			ceh_cnt_reg <= chip_select_n ? 6'h00
				: ceh_cnt_reg + {5'h00, seen_oe_reg && output_enable_n};
		end
	end
	////////////////////////
	clk_div_one_a: assert property (div_reg == 3'h1 && settle_reg > 3'h3 |-> !flash_clock_out)
		else $error("flash clock not the memory clock at ratio 1");
	clk_one_high_a: assert property (@(negedge aclk) div_reg == 3'h1 && settle_reg > 3'h3
		|-> flash_clock_out) else $error("flash clock low in the high half at ratio 1");
	clk_div_two_a: assert property (div_reg == 3'h2 && settle_reg > 3'h3
		|-> flash_clock_out != $past(flash_clock_out)) else $error("ratio 2 clock wrong");
	clk_div_four_a: assert property (div_reg == 3'h4 && settle_reg > 3'h5
		|-> flash_clock_out == !$past(flash_clock_out, 2)) else $error("ratio 4 clock wrong");
	adv_width_a: assert property ($rose(column_strobe_n) |-> adv_cnt_reg ==
		(div_reg == 3'h1 ? 4'h1 : (div_reg == 3'h2 ? 4'h3 : 4'h7))) else $error("strobe width");
	cs_lead_a: assert property ($fell(column_strobe_n)
		|-> !chip_select_n && !$past(chip_select_n)) else $error("strobe before select");
	oe_on_adv_a: assert property ($rose(column_strobe_n) |-> $fell(output_enable_n))
		else $error("output enable not on strobe end");
	cs_hold_a: assert property ($rose(chip_select_n) |-> ceh_cnt_reg == {1'b0, div_reg, 2'h0})
		else $error("select hold after output enable wrong");
	cs_gap_a: assert property ($rose(chip_select_n) |=> chip_select_n)
		else $error("no idle between bursts");
	idle_quiet_a: assert property (chip_select_n |-> column_strobe_n && output_enable_n)
		else $error("strobes active without select");
endmodule // sfbr_asserts

bind sfbr_top sfbr_asserts u_chk (.*);

// ---- test/sfbr_flash_model.sv ----
`timescale 1ns/10ps
module sfbr_flash_model (
	// flash pins
	input wire logic        aclk,
	input wire logic        flash_clock_out,
	input wire logic        chip_select_n,
	input wire logic        column_strobe_n,
	input wire logic        output_enable_n,
	input wire logic [25:0] flash_addr,
	// code the software picked for this flash
	input wire logic [3:0]  lat_code,
	output logic     [31:0] flash_data_in
);
	logic [4:0]  rise;
	logic [4:0]  beat;
	logic        act;
	logic [31:0] noise = 32'h5A3C9E17;
	// rise 0 is the first flash rise that sees the strobe low
	always @(posedge flash_clock_out) begin
		if (chip_select_n)
			act <= 1'b0;
		else if (!act && !column_strobe_n) begin
			act <= 1'b1;
			rise <= 5'h00;
		end else if (act)
			rise <= rise + 5'h01;
	end
	// released bus never holds a value: it churns every memory clock
	always @(posedge aclk)
		noise <= noise + 32'h9E3779B1;
	assign beat = rise + 5'h01 - {1'b0, lat_code};
	// beat n is out after rise code-1+n, so it is valid at rise code+n
	assign flash_data_in = (act && !chip_select_n && rise + 5'h01 >= {1'b0, lat_code})
		? {beat[2:0], 3'h0, flash_addr} : noise;
endmodule // sfbr_flash_model

// ---- test/test_sfbr_top.sv ----
`timescale 1ns/10ps
`include "sfbr_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_sfbr_top;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, flash_data_in, got, adr;
	logic [3:0]  s_axi_wstrb, lat_code;
	logic [1:0]  s_axi_bresp, s_axi_rresp, b_v;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, flash_clock_out, chip_select_n;
	logic        column_strobe_n, output_enable_n;
	logic [25:0] flash_addr;
	logic [33:0] rq[$], mq[$], e_v, m_v;
	logic [1:0]  bq[$];
	integer      bad_count, n_tests, seed, r, i, len, fld;
	localparam [33:0] ALL = 34'h3FFFFFFFF;
	sfbr_top dut (.*);
	sfbr_flash_model u_flash (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	////////////////////////
	task automatic wr(input [7:0] a, input [31:0] d, input [1:0] rs);
		logic pa, pw, pb;
		@(posedge aclk);
		bq.push_back(rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		{pa, pw, pb} = 3'h7;
		while (pb) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				pb = 1'b0;
			end
		end
	endtask
	task automatic rd(input [7:0] a, input [33:0] e, input [33:0] m);
		logic pa, pr;
		@(posedge aclk);
		rq.push_back(e);
		mq.push_back(m);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		{pa, pr} = 2'h3;
		while (pr) begin
			@(posedge aclk);
			if (pa && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				s_axi_rready <= 1'b0;
				got = s_axi_rdata;
				pr = 1'b0;
			end
		end
	endtask
	// waits on busy and pending; the watchdog bounds it
	task automatic poll;
		do rd(`SFBR_STATUS_OFF, 34'h0, 34'h0);
		while (got[0] !== 1'b0 || got[2] !== 1'b0);
	endtask
	task automatic drain;
		for (i = 0; i < len; i++)
			rd(`SFBR_READ_DATA_OFF, {2'h0, i[2:0], 3'h0, adr[25:0]}, ALL);
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e_v = rq.pop_front();
			m_v = mq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata} & m_v, e_v & m_v)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			b_v = bq.pop_front();
			`CHK(s_axi_bresp, b_v)
		end
	end
	initial begin
		repeat (40000) @(posedge aclk);
		bad_count++;
		wrap_up;
	end
	initial begin
		{seed, bad_count, n_tests} = {32'h6DDE8A66, 64'h0};
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
		s_axi_wstrb = 4'hF;
		lat_code = 4'h3;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SFBR_CLK_CTRL_OFF, 34'h0, ALL);
		rd(`SFBR_SYNC_CFG_OFF, 34'h74, ALL);
		rd(8'h18, {`SFBR_RESP_SLVERR, 32'h0}, ALL);
		wr(8'h18, 32'hFFFFFFFF, `SFBR_RESP_SLVERR);
		// every ratio select; the first run fills the fifo and sees start held pending until it drains
		for (r = 0; r < 4; r++) begin
			fld = (r == 0) ? 4 : 2 + {$random(seed)} % 8;
			len = (r == 0) ? 8 : 1 + {$random(seed)} % 8;
			adr = $random(seed);
			lat_code = fld[3:0] - 4'h1;
			wr(`SFBR_CLK_CTRL_OFF, r, `SFBR_RESP_OKAY);
			wr(`SFBR_SYNC_CFG_OFF, ((len - 1) << 4) | fld, `SFBR_RESP_OKAY);
			wr(`SFBR_READ_ADDR_OFF, adr, `SFBR_RESP_OKAY);
			wr(`SFBR_COMMAND_OFF, 32'h1, `SFBR_RESP_OKAY);
			poll;
			if (r == 0) begin
				rd(`SFBR_STATUS_OFF, 34'h82, ALL);
				wr(`SFBR_COMMAND_OFF, 32'h1, `SFBR_RESP_OKAY);
				rd(`SFBR_STATUS_OFF, 34'h86, ALL);
				drain;
				poll;
			end
			drain;
			rd(`SFBR_READ_DATA_OFF, 34'h0, ALL);
		end
		wrap_up;
	end
endmodule // test_sfbr_top
